/* File: design/timer1_pkg.sv */
// constants and types for the timer interrupt and dead-time block
`default_nettype none
package timer1_pkg;
    // processor i/o address space
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] DEAD_TIME_ADDR = 6'h24;
    localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 6'h39;
    localparam logic [ADDR_W-1:0] IRQ_FLAGS_ADDR = 6'h38;
    localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
    localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

    // bit positions shared by mask and flag registers
    localparam int CMP_D_BIT = 7;
    localparam int CMP_A_BIT = 6;
    localparam int CMP_B_BIT = 5;
    localparam int OVERFLOW_BIT = 2;
    localparam logic [DATA_W-1:0] FLAG_BITS_USED = 8'he4;

    // interrupt vectors of this timer
    localparam int VEC_W = 6;
    localparam logic [VEC_W-1:0] VEC_CMP_D = 6'h10;
    localparam logic [VEC_W-1:0] VEC_CMP_A = 6'h03;
    localparam logic [VEC_W-1:0] VEC_CMP_B = 6'h09;
    localparam logic [VEC_W-1:0] VEC_OVERFLOW = 6'h04;

    // counter and dead-time widths
    localparam int COUNT_W = 10;
    localparam int DT_W = 4;
    localparam logic [DT_W-1:0] DT_ZERO = 4'h0;
    localparam logic [DT_W-1:0] DT_ONE = 4'h1;
    localparam int CHANNELS = 3;

    // waveform mode select: wgm bit 0 set in pwm selects the bottom-wrap modes
    localparam int WGM_BOTTOM_BIT = 0;

    // dead-time register fields
    typedef struct packed {
        logic [DT_W-1:0] true_output;
        logic [DT_W-1:0] inverted_output;
    } dead_time_t;

    // interrupt request lines, one per vector
    typedef struct packed {
        logic cmp_d;
        logic cmp_a;
        logic cmp_b;
        logic overflow;
    } irq_req_t;

    // compare values from the counter core
    typedef struct packed {
        logic [COUNT_W-1:0] d;
        logic [COUNT_W-1:0] b;
        logic [COUNT_W-1:0] a;
    } compare_set_t;
endpackage : timer1_pkg
`default_nettype wire

/* File: design/dead_time_gen.sv */
// dead-time generator for one complementary output pair
`default_nettype none
module dead_time_gen (
    input wire logic clock,
    input wire logic rst,
    input wire logic prescale_tick,
    input wire logic wave_in,
    input wire logic [timer1_pkg::DT_W-1:0] true_delay,
    input wire logic [timer1_pkg::DT_W-1:0] inv_delay,
    output logic out_true,
    output logic out_inv
);
    import timer1_pkg::*;

    typedef enum logic [2:0] {
        ST_WAIT = 3'b001,
        ST_TRUE = 3'b010,
        ST_INV = 3'b100
    } dt_state_t;

    dt_state_t state_reg, state_next;
    logic [DT_W-1:0] count_reg, count_next;
    logic wave_reg, wave_next;
    logic true_reg, true_next;
    logic inv_reg, inv_next;

    // any edge of the wave drops both outputs, then the rising side waits its delay
    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        wave_next = wave_in;
        true_next = true_reg;
        inv_next = inv_reg;
        if (wave_in != wave_reg) begin
            true_next = 1'b0;
            inv_next = 1'b0;
            state_next = ST_WAIT;
            count_next = wave_in ? true_delay : inv_delay;
        end else begin
            case (state_reg)
                ST_WAIT: begin
                    // delay counted in prescaled timer clocks, 0 to 15
                    if (count_reg == DT_ZERO) begin
                        state_next = wave_reg ? ST_TRUE : ST_INV;
                        true_next = wave_reg;
                        inv_next = ~wave_reg;
                    end else if (prescale_tick) begin
                        count_next = count_reg - DT_ONE;
                    end
                end
                ST_TRUE: begin
                    true_next = 1'b1;
                    inv_next = 1'b0;
                end
                ST_INV: begin
                    true_next = 1'b0;
                    inv_next = 1'b1;
                end
                default: begin
                    state_next = ST_WAIT;
                    true_next = 1'b0;
                    inv_next = 1'b0;
                end
            endcase
        end
    end

    // state registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= ST_WAIT;
            count_reg <= DT_ZERO;
            wave_reg <= 1'b0;
            true_reg <= 1'b0;
            inv_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            wave_reg <= wave_next;
            true_reg <= true_next;
            inv_reg <= inv_next;
        end
    end

    assign out_true = true_reg;
    assign out_inv = inv_reg;
endmodule : dead_time_gen
`default_nettype wire

/* File: design/timer1_irq_dead_time.sv */
// interrupt mask, interrupt flags and dead-time logic of the fast timer
`default_nettype none
module timer1_irq_dead_time (
    input wire logic clock,
    input wire logic rst,
    // processor i/o register port
    input wire logic [timer1_pkg::ADDR_W-1:0] io_addr,
    input wire logic [timer1_pkg::DATA_W-1:0] io_wdata,
    input wire logic io_write,
    input wire logic io_read,
    output logic [timer1_pkg::DATA_W-1:0] io_rdata,
    // processor interrupt side
    input wire logic global_irq_enable,
    input wire logic vector_taken,
    input wire logic [timer1_pkg::VEC_W-1:0] vector_number,
    output timer1_pkg::irq_req_t irq_request,
    // counter core side
    input wire logic [timer1_pkg::COUNT_W-1:0] counter_value,
    input wire logic count_step,
    input wire timer1_pkg::compare_set_t compare_value,
    input wire logic top_wrap,
    input wire logic bottom_load,
    input wire logic pwm_mode,
    input wire logic [1:0] wgm_mode,
    input wire logic prescale_tick,
    input wire logic [timer1_pkg::CHANNELS-1:0] wave_in,
    output logic [timer1_pkg::CHANNELS-1:0] compare_output_pin,
    output logic [timer1_pkg::CHANNELS-1:0] compare_output_pin_n
);
    import timer1_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // a match counts only when the counter itself stepped onto the value
    function automatic logic counted_match(input logic step, input logic [COUNT_W-1:0] cnt,
                                           input logic [COUNT_W-1:0] cmp);
        counted_match = step && (cnt == cmp);
    endfunction : counted_match

    // true when a register write hits the given address
    function automatic logic write_hit(input logic wr, input logic [ADDR_W-1:0] addr,
                                       input logic [ADDR_W-1:0] target);
        write_hit = wr && (addr == target);
    endfunction : write_hit

    // next value of one sticky flag: the set beats any clear
    function automatic logic flag_update(input logic cur, input logic set_evt, input logic clr_evt);
        flag_update = set_evt | (cur & ~clr_evt);
    endfunction : flag_update

    // true when the processor executes the given vector this cycle
    function automatic logic vector_hit(input logic taken, input logic [VEC_W-1:0] num,
                                        input logic [VEC_W-1:0] target);
        vector_hit = taken && (num == target);
    endfunction : vector_hit

    // a request needs the global bit, its enable and its flag together
    function automatic logic irq_gate(input logic global_en, input logic enable, input logic flag);
        irq_gate = global_en & enable & flag;
    endfunction : irq_gate

    ////////////////////////////////////////////////////////////////////////
    // state

    // control registers
    logic [DATA_W-1:0] mask_reg;
    logic [DATA_W-1:0] mask_next;
    dead_time_t dead_time_reg;
    dead_time_t dead_time_next;
    // flag state and its pipeline
    logic [DATA_W-1:0] flags_reg;
    logic [DATA_W-1:0] flags_next;
    logic [DATA_W-1:0] clr_pend_reg;
    logic [DATA_W-1:0] clr_pend_next;
    logic [DATA_W-1:0] event_reg;
    logic [DATA_W-1:0] event_next;
    logic [DATA_W-1:0] vec_clear;
    logic overflow_event;
    // read port
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;

    ////////////////////////////////////////////////////////////////////////
    // event capture

    // overflow source depends on the waveform mode
    always_comb begin
        if (pwm_mode && wgm_mode[WGM_BOTTOM_BIT]) begin
            overflow_event = bottom_load;
        end else begin
            overflow_event = top_wrap;
        end
    end

    // compare and overflow events, held one cycle as the synchronisation delay
    always_comb begin
        event_next = READ_ZERO;
        event_next[CMP_D_BIT] = counted_match(count_step, counter_value, compare_value.d);
        event_next[CMP_A_BIT] = counted_match(count_step, counter_value, compare_value.a);
        event_next[CMP_B_BIT] = counted_match(count_step, counter_value, compare_value.b);
        event_next[OVERFLOW_BIT] = overflow_event;
    end

    // event stage: this register is the synchronisation delay before a flag sets
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            event_reg <= REG_RESET;
        end else begin
            event_reg <= event_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register file

    // vector execution clears the matching flag in the same cycle
    always_comb begin
        vec_clear = READ_ZERO;
        vec_clear[CMP_D_BIT] = vector_hit(vector_taken, vector_number, VEC_CMP_D);
        vec_clear[CMP_A_BIT] = vector_hit(vector_taken, vector_number, VEC_CMP_A);
        vec_clear[CMP_B_BIT] = vector_hit(vector_taken, vector_number, VEC_CMP_B);
        vec_clear[OVERFLOW_BIT] = vector_hit(vector_taken, vector_number, VEC_OVERFLOW);
    end

    // mask register: every bit read/write, the other timer's bits kept as written
    always_comb begin
        mask_next = mask_reg;
        if (write_hit(io_write, io_addr, IRQ_MASK_ADDR)) begin
            mask_next = io_wdata;
        end
    end

    // mask register stage
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mask_reg <= REG_RESET;
        end else begin
            mask_reg <= mask_next;
        end
    end

    // dead-time register: upper field for the true output, lower for the inverted one
    always_comb begin
        dead_time_next = dead_time_reg;
        if (write_hit(io_write, io_addr, DEAD_TIME_ADDR)) begin
            dead_time_next.true_output = io_wdata[DATA_W-1:DT_W];
            dead_time_next.inverted_output = io_wdata[DT_W-1:0];
        end
    end

    // dead-time register stage
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dead_time_reg <= REG_RESET;
        end else begin
            dead_time_reg <= dead_time_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt flags

    // a written one waits here for one cycle before it clears its flag
    always_comb begin
        clr_pend_next = READ_ZERO;
        if (write_hit(io_write, io_addr, IRQ_FLAGS_ADDR)) begin
            clr_pend_next = io_wdata & FLAG_BITS_USED;
        end
    end

    // clear pending stage
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            clr_pend_reg <= REG_RESET;
        end else begin
            clr_pend_reg <= clr_pend_next;
        end
    end

    // sticky flags: a set beats a clear that falls in the same cycle
    always_comb begin
        flags_next = READ_ZERO;
        for (int i = 0; i < DATA_W; i++) begin
            // cleared by vector or written one
            flags_next[i] = flag_update(flags_reg[i], event_reg[i], clr_pend_reg[i] | vec_clear[i]);
        end
        // unused flag positions never set and read as zero
        flags_next = flags_next & FLAG_BITS_USED;
    end

    // flag register stage
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            flags_reg <= REG_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port

    // read data registered, unmapped addresses return zero
    always_comb begin
        rdata_next = rdata_reg;
        if (io_read) begin
            case (io_addr)
                IRQ_MASK_ADDR: rdata_next = mask_reg;
                DEAD_TIME_ADDR: rdata_next = dead_time_reg;
                IRQ_FLAGS_ADDR: rdata_next = flags_reg;
                default: rdata_next = READ_ZERO;
            endcase
        end
    end

    // read data stage: the value holds until the next read
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_reg <= REG_RESET;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign io_rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // interrupt requests

    // each request needs the global bit, its enable and its flag
    always_comb begin
        irq_request.cmp_d = irq_gate(global_irq_enable, mask_reg[CMP_D_BIT], flags_reg[CMP_D_BIT]);
        irq_request.cmp_a = irq_gate(global_irq_enable, mask_reg[CMP_A_BIT], flags_reg[CMP_A_BIT]);
        irq_request.cmp_b = irq_gate(global_irq_enable, mask_reg[CMP_B_BIT], flags_reg[CMP_B_BIT]);
        irq_request.overflow = irq_gate(global_irq_enable, mask_reg[OVERFLOW_BIT], flags_reg[OVERFLOW_BIT]);
    end

    ////////////////////////////////////////////////////////////////////////
    // dead-time generators

    // both delays come straight from the register fields
    logic [DT_W-1:0] true_delay;
    logic [DT_W-1:0] inv_delay;
    assign true_delay = dead_time_reg.true_output;
    assign inv_delay = dead_time_reg.inverted_output;

    // one generator per channel, all sharing the dead-time register
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_dead_time
        dead_time_gen i_dead_time_gen (
            .clock(clock),
            .rst(rst),
            .prescale_tick(prescale_tick),
            .wave_in(wave_in[ch]),
            .true_delay(true_delay),
            .inv_delay(inv_delay),
            .out_true(compare_output_pin[ch]),
            .out_inv(compare_output_pin_n[ch])
        );
    end
endmodule : timer1_irq_dead_time
`default_nettype wire

/* File: testbench/timer1_irq_dead_time_properties.sv */
// port assertions for the timer interrupt and dead-time block
`default_nettype none
module timer1_irq_dead_time_properties
    import timer1_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] io_addr,
    input wire logic [DATA_W-1:0] io_wdata,
    input wire logic io_write,
    input wire logic global_irq_enable,
    input wire logic vector_taken,
    input wire logic [VEC_W-1:0] vector_number,
    input wire irq_req_t irq_request,
    input wire logic [COUNT_W-1:0] counter_value,
    input wire logic count_step,
    input wire compare_set_t compare_value,
    input wire logic top_wrap,
    input wire logic bottom_load,
    input wire logic pwm_mode,
    input wire logic [1:0] wgm_mode,
    input wire logic [CHANNELS-1:0] wave_in,
    input wire logic [CHANNELS-1:0] compare_output_pin,
    input wire logic [CHANNELS-1:0] compare_output_pin_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mask_sh, dt_sh;
    logic match_a, match_b;
    // counted matches on channels a and b
    assign match_a = count_step && counter_value == compare_value.a;
    assign match_b = count_step && counter_value == compare_value.b;
    // shadow copies of mask and dead-time writes
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mask_sh <= 8'h00;
            dt_sh <= 8'h00;
        end else if (io_write && io_addr == IRQ_MASK_ADDR) begin
            mask_sh <= io_wdata;
        end else if (io_write && io_addr == DEAD_TIME_ADDR) begin
            dt_sh <= io_wdata;
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    a_cmp_a_req: assert property (
        match_a && mask_sh[6] && global_irq_enable |-> ##2 (irq_request.cmp_a || !global_irq_enable || !mask_sh[6]))
        else $error("channel a request missing");
    a_b_needs_step: assert property (
        $rose(irq_request.cmp_b) && $stable(global_irq_enable) && $stable(mask_sh) |-> $past(match_b, 2))
        else $error("channel b request without counted match");
    a_vec_clear: assert property (
        vector_taken && vector_number == VEC_CMP_A && !$past(match_a) |=> !irq_request.cmp_a)
        else $error("channel a flag kept after vector");
    a_ovf_top: assert property (
        top_wrap && !(pwm_mode && wgm_mode[0]) && mask_sh[2] && global_irq_enable
        |-> ##2 (irq_request.overflow || !global_irq_enable || !mask_sh[2]))
        else $error("overflow at top missing");
    a_ovf_bottom: assert property (
        bottom_load && pwm_mode && wgm_mode[0] && mask_sh[2] && global_irq_enable
        |-> ##2 (irq_request.overflow || !global_irq_enable || !mask_sh[2]))
        else $error("overflow at bottom missing");
    a_irq_gate: assert property (
        4'(irq_request) == (4'(irq_request) & {4{global_irq_enable}} & {mask_sh[7:5], mask_sh[2]}))
        else $error("request without global or enable bit");
    a_dt_zero: assert property (
        $rose(wave_in[0]) && dt_sh[7:4] == 4'h0 ##1 wave_in[0] [*2] |=> compare_output_pin[0])
        else $error("zero dead time output late");
    a_dt_off: assert property (
        $changed(wave_in[1]) |=> !compare_output_pin[1] && !compare_output_pin_n[1])
        else $error("outputs not both low after change");
endmodule : timer1_irq_dead_time_properties
bind timer1_irq_dead_time timer1_irq_dead_time_properties i_timer1_irq_dead_time_properties (
    .clock(clock), .rst(rst), .io_addr(io_addr), .io_wdata(io_wdata), .io_write(io_write),
    .global_irq_enable(global_irq_enable), .vector_taken(vector_taken), .vector_number(vector_number),
    .irq_request(irq_request), .counter_value(counter_value), .count_step(count_step),
    .compare_value(compare_value), .top_wrap(top_wrap), .bottom_load(bottom_load), .pwm_mode(pwm_mode),
    .wgm_mode(wgm_mode), .wave_in(wave_in), .compare_output_pin(compare_output_pin),
    .compare_output_pin_n(compare_output_pin_n)
);
`default_nettype wire

/* File: testbench/cpu_irq_model.sv */
// processor model that takes pending timer interrupts
`default_nettype none
module cpu_irq_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic enable,
    input wire logic [7:0] latency,
    input wire timer1_pkg::irq_req_t irq_request,
    output logic vector_taken,
    output logic [timer1_pkg::VEC_W-1:0] vector_number
);
    timeunit 1ns;
    timeprecision 1ns;
    import timer1_pkg::*;
    logic [7:0] wait_cnt;
    always @(negedge clock or posedge rst) begin
        if (rst) begin
            vector_taken <= 1'b0;
            vector_number <= '0;
            wait_cnt <= 8'h00;
        end else begin
            vector_taken <= 1'b0;
            vector_number <= ~vector_number;
            if (!enable || irq_request == '0 || vector_taken) begin
                wait_cnt <= 8'h00;
            end else if (wait_cnt < latency) begin
                wait_cnt <= wait_cnt + 8'h01;
            end else begin
                vector_taken <= 1'b1;
                wait_cnt <= 8'h00;
                vector_number <= irq_request.cmp_a ? VEC_CMP_A : irq_request.overflow ? VEC_OVERFLOW :
                    irq_request.cmp_b ? VEC_CMP_B : VEC_CMP_D;
            end
        end
    end
endmodule : cpu_irq_model
`default_nettype wire

/* File: testbench/tb_timer1_irq_dead_time.sv */
// self-checking bench for the timer interrupt and dead-time block
`default_nettype none
module tb_timer1_irq_dead_time;
    timeunit 1ns;
    timeprecision 1ns;
    import timer1_pkg::*;
    logic clock = 1'b0, rst = 1'b1, io_write = 1'b0, io_read = 1'b0, count_step = 1'b0;
    logic top_wrap = 1'b0, bottom_load = 1'b0, pwm_mode = 1'b0, prescale_tick = 1'b1;
    logic global_irq_enable = 1'b0, cpu_on = 1'b0, vector_taken;
    logic [1:0] wgm_mode = 2'h0;
    logic [ADDR_W-1:0] io_addr = '0;
    logic [DATA_W-1:0] io_wdata = '0, io_rdata, cpu_lat = 8'h00;
    logic [COUNT_W-1:0] counter_value = '0;
    logic [CHANNELS-1:0] wave_in = '0, compare_output_pin, compare_output_pin_n;
    logic [VEC_W-1:0] vector_number;
    compare_set_t compare_value = '0;
    irq_req_t irq_request;
    int bad_count = 0, n_checks = 0;
    // bus clock
    always #25 clock = ~clock;
    timer1_irq_dead_time i_timer1_irq_dead_time (.clock, .rst, .io_addr, .io_wdata, .io_write, .io_read,
        .io_rdata, .global_irq_enable, .vector_taken, .vector_number, .irq_request, .counter_value,
        .count_step, .compare_value, .top_wrap, .bottom_load, .pwm_mode, .wgm_mode, .prescale_tick,
        .wave_in, .compare_output_pin, .compare_output_pin_n);
    cpu_irq_model i_cpu_irq_model (.clock, .rst, .enable(cpu_on), .latency(cpu_lat), .irq_request,
        .vector_taken, .vector_number);
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic test_done();
        if (bad_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clock);
        io_addr = a;
        io_wdata = d;
        io_write = 1'b1;
        @(negedge clock);
        io_write = 1'b0;
    endtask : wr
    task automatic rdchk(input logic [5:0] a, input logic [7:0] e);
        @(negedge clock);
        io_addr = a;
        io_read = 1'b1;
        @(negedge clock);
        io_read = 1'b0;
        check(io_rdata, e);
    endtask : rdchk
    task automatic pulse(input logic [COUNT_W-1:0] c, input logic [2:0] ev);
        @(negedge clock);
        counter_value = c;
        {count_step, top_wrap, bottom_load} = ev;
        @(negedge clock);
        {count_step, top_wrap, bottom_load} = 3'h0;
    endtask : pulse
    task automatic wait_vec(input logic [5:0] v);
        int i;
        for (i = 0; i < 40 && vector_taken !== 1'b1; i++) @(negedge clock);
        if (i == 40) begin
            bad_count++;
            $display("FAIL %0t no vector taken", $time);
            test_done();
        end
        check(8'(vector_number), 8'(v));
        @(negedge clock);
    endtask : wait_vec
    task automatic dt_step(input logic [2:0] w, input logic [7:0] e);
        int n;
        @(negedge clock);
        wave_in = w;
        for (n = 0; n < 40 && (w[0] ? compare_output_pin : compare_output_pin_n) !== 3'h7; n++) @(negedge clock);
        check(8'(n), e);
        if (n == 40) test_done();
    endtask : dt_step
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rdchk(IRQ_MASK_ADDR, REG_RESET);
        rdchk(DEAD_TIME_ADDR, REG_RESET);
        rdchk(IRQ_FLAGS_ADDR, READ_ZERO);
        wr(IRQ_MASK_ADDR, 8'h5a);
        wr(DEAD_TIME_ADDR, 8'ha5);
        wr(6'h3f, 8'hff);
        rdchk(IRQ_MASK_ADDR, 8'h5a);
        rdchk(DEAD_TIME_ADDR, 8'ha5);
        rdchk(6'h3f, READ_ZERO);
    endtask : t_regs
    task automatic t_cmp();
        logic [5:0] vec [3] = '{VEC_CMP_A, VEC_CMP_B, VEC_CMP_D};
        logic [7:0] en [3] = '{8'h40, 8'h20, 8'h80};
        compare_value = {10'h3f0, 10'h155, 10'h02a};
        global_irq_enable = 1'b1;
        cpu_on = 1'b1;
        for (int k = 0; k < 3; k++) begin
            wr(IRQ_MASK_ADDR, en[k]);
            pulse(compare_value[k*10 +: 10], 3'h4);
            wait_vec(vec[k]);
            rdchk(IRQ_FLAGS_ADDR, READ_ZERO);
        end
    endtask : t_cmp
    task automatic t_pend();
        cpu_on = 1'b0;
        wr(IRQ_MASK_ADDR, 8'h00);
        pulse(compare_value.b, 3'h0);
        rdchk(IRQ_FLAGS_ADDR, READ_ZERO);
        pulse(compare_value.d, 3'h4);
        repeat (2) @(negedge clock);
        check(8'(irq_request), 8'h00);
        rdchk(IRQ_FLAGS_ADDR, 8'h80);
        wr(IRQ_FLAGS_ADDR, 8'h7f);
        rdchk(IRQ_FLAGS_ADDR, 8'h80);
        wr(IRQ_MASK_ADDR, 8'h80);
        check(8'(irq_request), 8'h08);
        wr(IRQ_FLAGS_ADDR, 8'h80);
        @(negedge clock);
        check(8'(irq_request), 8'h00);
    endtask : t_pend
    task automatic t_ovf();
        logic [2:0] md [5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
        logic bot;
        cpu_lat = 8'h05;
        wr(IRQ_MASK_ADDR, 8'h04);
        cpu_on = 1'b1;
        for (int m = 0; m < 5; m++) begin
            {pwm_mode, wgm_mode} = md[m];
            bot = md[m][2] & md[m][0];
            pulse(10'h000, bot ? 3'h2 : 3'h1);
            repeat (3) @(negedge clock);
            check(8'(irq_request), 8'h00);
            pulse(10'h000, bot ? 3'h1 : 3'h2);
            wait_vec(VEC_OVERFLOW);
        end
    endtask : t_ovf
    task automatic t_dead();
        wr(DEAD_TIME_ADDR, 8'h30);
        dt_step(3'h7, 8'h05);
        dt_step(3'h0, 8'h02);
        wr(DEAD_TIME_ADDR, 8'h0f);
        dt_step(3'h7, 8'h02);
        dt_step(3'h0, 8'h11);
    endtask : t_dead
    // delay counts only prescaled ticks, never plain clocks
    task automatic t_tick();
        wr(DEAD_TIME_ADDR, 8'h20);
        prescale_tick = 1'b0;
        wave_in = 3'h7;
        repeat (6) @(negedge clock);
        check(8'(compare_output_pin), 8'h00);
        for (int t = 0; t < 2; t++) begin
            prescale_tick = 1'b1;
            @(negedge clock);
            prescale_tick = 1'b0;
            @(negedge clock);
        end
        @(negedge clock);
        check(8'(compare_output_pin), 8'h07);
        prescale_tick = 1'b1;
    endtask : t_tick
    // reset, then the scenarios in turn
    initial begin
        repeat (16) @(negedge clock);
        rst = 1'b0;
        t_regs();
        t_cmp();
        t_pend();
        t_ovf();
        t_dead();
        t_tick();
        test_done();
    end
endmodule : tb_timer1_irq_dead_time
`default_nettype wire
